/* File: logic/dtc_timer.sv */
// Dual timer/counter with four modes, count-pin edge detection and gating.
// Assumes pins are synchronous to mclk and the interrupt controller pulses an
// acknowledge when it vectors to a timer service routine.
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns

// Contract
// - Count pins sampled at phase four, falling
// - Counts update at phase three, next cycle
// - Overflow flags set at phase three
// - Counter select bits two and six
// - Two-bit mode field per timer
// - Tick every twelve or four clocks
// - Reset clears both fast time-base bits
// - Mode 0 uses thirteen bits
// - Prescaler carry bumps high byte, flag
// - Count only when run and gate allow
// - Counter select picks ticks or edges
// - Thirteen-bit wrap sets overflow flag
// - Mode 1 is sixteen-bit wrap counter
// - Mode 2 reloads low from high
// - Timer B frozen in mode 3
// - Split mode low byte uses A controls
// - Split high byte uses B run, flag
// - B runs without run bit, flag
// - Timer B overflow drives baud tick
// - Acknowledge clears matching overflow flag
module dtc_timer #(
  parameter int ADDR_W = 3
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire dtc_pkg::dtc_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic timer_a_count_pin,
  input wire logic timer_b_count_pin,
  input wire logic timer_a_gate_pin,
  input wire logic timer_b_gate_pin,
  input wire logic irq_ack_a,
  input wire logic irq_ack_b,
  output logic timer_a_overflow_flag,
  output logic timer_b_overflow_flag,
  output logic baud_tick
);

  // Port width is fixed by the three-bit offsets
  if (ADDR_W != 3) begin : g_bad_addr
    $error("dtc_timer: ADDR_W must be 3");
  end

  dtc_pkg::dtc_state_t s; // Registered state
  dtc_pkg::dtc_state_t next_s; // Next state
  dtc_pkg::dtc_mode_t mode_a; // Decoded mode, timer A
  dtc_pkg::dtc_mode_t mode_b; // Decoded mode, timer B
  logic ph3; // Update phase of a machine cycle
  logic tick_a; // Time-base tick for timer A
  logic tick_b; // Time-base tick for timer B
  logic en_a; // Timer A (or split low byte) steps
  logic en_b; // Timer B steps
  logic en_ah; // Split high byte steps
  logic split; // Timer A in split mode
  dtc_pkg::dtc_step_t st_a; // Step result, timer A
  dtc_pkg::dtc_step_t st_b; // Step result, timer B
  logic set_a; // Hardware sets timer A flag
  logic set_b; // Hardware sets timer B flag
  logic ovf_b; // Timer B overflow for the baud tick
  logic wr_ctrl; // Write to the control register

  // One count step for modes 0 to 2
  function automatic dtc_pkg::dtc_step_t step(input dtc_pkg::dtc_mode_t m,
                                              input logic [7:0] lo,
                                              input logic [7:0] hi);
    dtc_pkg::dtc_step_t r;
    r.ovf = 1'b0;
    r.lo = lo;
    r.hi = hi;
    case (m)
      // thirteen-bit count, top three bits kept
      dtc_pkg::DTC_M13: begin
        r.lo[4:0] = lo[4:0] + 5'h01;
        if (lo[4:0] == dtc_pkg::PRE_MAX) begin
          r.hi = hi + 8'h01;
          r.ovf = (hi == dtc_pkg::BYTE_MAX);
        end
      end
      dtc_pkg::DTC_M16: begin
        {r.hi, r.lo} = {hi, lo} + 16'h0001;
        r.ovf = ({hi, lo} == 16'hFFFF);
      end
      // low byte reloads, high byte kept
      dtc_pkg::DTC_MRLD: begin
        if (lo == dtc_pkg::BYTE_MAX) begin
          r.lo = hi;
          r.ovf = 1'b1;
        end else begin
          r.lo = lo + 8'h01;
        end
      end
      default: begin
        r.ovf = 1'b0;
      end
    endcase
    return r;
  endfunction

  // Decode of mode fields and time base
  always_comb begin
    mode_a = dtc_pkg::dtc_mode_t'(s.mode_reg[dtc_pkg::MODE_A_LSB +: 2]);
    mode_b = dtc_pkg::dtc_mode_t'(s.mode_reg[dtc_pkg::MODE_B_LSB +: 2]);
    split = (mode_a == dtc_pkg::DTC_MSPLIT);
    ph3 = (s.phase == dtc_pkg::DTC_PH3);
    // fast bit ticks every machine cycle, else every third
    tick_a = s.fast_a | (s.div3 == 2'h0);
    tick_b = s.fast_b | (s.div3 == 2'h0);
  end

  // Enables for each counter
  always_comb begin
    // run bit and gate decide counting
    // select ticks or detected pin edges
    // counter select bits of the mode register
    en_a = ph3 & s.run_a
         & (~s.mode_reg[dtc_pkg::GSEL_A_BIT] | timer_a_gate_pin)
         & (s.mode_reg[dtc_pkg::CSEL_A_BIT] ? s.pend_a : tick_a);
    // in split mode timer B ignores its run bit
    // timer B never steps in its own mode 3
    en_b = ph3 & (split | s.run_b) & (mode_b != dtc_pkg::DTC_MSPLIT)
         & (~s.mode_reg[dtc_pkg::GSEL_B_BIT] | timer_b_gate_pin)
         & (s.mode_reg[dtc_pkg::CSEL_B_BIT] ? s.pend_b : tick_b);
    // split high byte counts ticks under timer B run
    en_ah = ph3 & split & s.run_b & tick_a;
  end

  // Step results and flag sources
  always_comb begin
    st_a = step(mode_a, s.a_lo, s.a_hi);
    st_b = step(mode_b, s.b_lo, s.b_hi);
    ovf_b = en_b & st_b.ovf;
    // split low byte overflow sets timer A flag
    set_a = split ? (en_a & (s.a_lo == dtc_pkg::BYTE_MAX)) : (en_a & st_a.ovf);
    // timer B loses its flag to the split high byte
    set_b = split ? (en_ah & (s.a_hi == dtc_pkg::BYTE_MAX)) : ovf_b;
    wr_ctrl = bus_req.wr & (bus_req.addr == dtc_pkg::CTRL_OFS);
  end

  // Next-state logic: phases, pins, counters, bus
  always_comb begin
    next_s = s;
    // four phases, slow tick every third machine cycle
    next_s.phase = dtc_pkg::dtc_phase_t'(s.phase + 2'h1);
    if (s.phase == dtc_pkg::DTC_PH4) begin
      next_s.div3 = (s.div3 == dtc_pkg::SLOW_MC - 2'h1) ? 2'h0 : s.div3 + 2'h1;
      // sample at phase four, falling edge is high then low
      next_s.samp_a = timer_a_count_pin;
      next_s.samp_b = timer_b_count_pin;
      // edge is held and counted at next phase three
      next_s.pend_a = s.samp_a & ~timer_a_count_pin;
      next_s.pend_b = s.samp_b & ~timer_b_count_pin;
    end
    // counters move only at phase three
    if (split) begin
      if (en_a) begin
        next_s.a_lo = s.a_lo + 8'h01;
      end
      if (en_ah) begin
        next_s.a_hi = s.a_hi + 8'h01;
      end
    end else if (en_a) begin
      next_s.a_lo = st_a.lo;
      next_s.a_hi = st_a.hi;
    end
    if (en_b) begin
      next_s.b_lo = st_b.lo;
      next_s.b_hi = st_b.hi;
    end
    // baud tick from timer B, also during split mode
    next_s.baud = ovf_b;
    // Software writes win over counting on the same byte
    if (bus_req.wr) begin
      if (bus_req.addr == dtc_pkg::MODE_OFS) begin
        next_s.mode_reg = bus_req.wdata;
      end else if (bus_req.addr == dtc_pkg::CTRL_OFS) begin
        next_s.run_a = bus_req.wdata[dtc_pkg::RUN_A_BIT];
        next_s.run_b = bus_req.wdata[dtc_pkg::RUN_B_BIT];
      end else if (bus_req.addr == dtc_pkg::CLKC_OFS) begin
        next_s.fast_a = bus_req.wdata[dtc_pkg::FAST_A_BIT];
        next_s.fast_b = bus_req.wdata[dtc_pkg::FAST_B_BIT];
      end else if (bus_req.addr == dtc_pkg::ALO_OFS) begin
        next_s.a_lo = bus_req.wdata;
      end else if (bus_req.addr == dtc_pkg::AHI_OFS) begin
        next_s.a_hi = bus_req.wdata;
      end else if (bus_req.addr == dtc_pkg::BLO_OFS) begin
        next_s.b_lo = bus_req.wdata;
      end else if (bus_req.addr == dtc_pkg::BHI_OFS) begin
        next_s.b_hi = bus_req.wdata;
      end
    end
    // acknowledge clears; a set at phase three wins
    next_s.flag_a = set_a | (wr_ctrl ? bus_req.wdata[dtc_pkg::FLAG_A_BIT]
                                     : (s.flag_a & ~irq_ack_a));
    next_s.flag_b = set_b | (wr_ctrl ? bus_req.wdata[dtc_pkg::FLAG_B_BIT]
                                     : (s.flag_b & ~irq_ack_b));
    // Read data for the cycle after the strobe, zero otherwise
    next_s.rdata = 8'h00;
    if (bus_req.rd) begin
      if (bus_req.addr == dtc_pkg::MODE_OFS) begin
        next_s.rdata = s.mode_reg;
      end else if (bus_req.addr == dtc_pkg::CTRL_OFS) begin
        next_s.rdata[dtc_pkg::RUN_A_BIT] = s.run_a;
        next_s.rdata[dtc_pkg::FLAG_A_BIT] = s.flag_a;
        next_s.rdata[dtc_pkg::RUN_B_BIT] = s.run_b;
        next_s.rdata[dtc_pkg::FLAG_B_BIT] = s.flag_b;
      end else if (bus_req.addr == dtc_pkg::CLKC_OFS) begin
        next_s.rdata[dtc_pkg::FAST_A_BIT] = s.fast_a;
        next_s.rdata[dtc_pkg::FAST_B_BIT] = s.fast_b;
      end else if (bus_req.addr == dtc_pkg::ALO_OFS) begin
        next_s.rdata = s.a_lo;
      end else if (bus_req.addr == dtc_pkg::AHI_OFS) begin
        next_s.rdata = s.a_hi;
      end else if (bus_req.addr == dtc_pkg::BLO_OFS) begin
        next_s.rdata = s.b_lo;
      end else if (bus_req.addr == dtc_pkg::BHI_OFS) begin
        next_s.rdata = s.b_hi;
      end
    end
  end

  // State register with synchronous reset, constants only in the reset branch
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // both fast bits cleared
      // Sample flops start low, so an idle-high pin gives no false edge
      s <= '{mode_reg: dtc_pkg::MODE_RST, run_a: 1'b0, run_b: 1'b0,
             flag_a: 1'b0, flag_b: 1'b0, fast_a: 1'b0, fast_b: 1'b0,
             a_lo: dtc_pkg::BYTE_RST, a_hi: dtc_pkg::BYTE_RST,
             b_lo: dtc_pkg::BYTE_RST, b_hi: dtc_pkg::BYTE_RST,
             phase: dtc_pkg::DTC_PH1, div3: 2'h0, samp_a: 1'b0, samp_b: 1'b0,
             pend_a: 1'b0, pend_b: 1'b0, rdata: 8'h00, baud: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flip-flops
  assign bus_rdata = s.rdata;
  assign timer_a_overflow_flag = s.flag_a;
  assign timer_b_overflow_flag = s.flag_b;
  assign baud_tick = s.baud;

  // Phase four is always followed by phase one
  phase_order_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s.phase == dtc_pkg::DTC_PH4 |=> s.phase == dtc_pkg::DTC_PH1 ##3
    s.phase == dtc_pkg::DTC_PH4)
    else $error("machine cycle phases out of order");

  // Count bytes change only after phase three or a write
  count_phase_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ($changed(s.a_lo) || $changed(s.b_lo)) && !$past(bus_req.wr)
    |-> $past(s.phase) == dtc_pkg::DTC_PH3)
    else $error("count byte changed outside phase three");

  // Flags rise only from phase three
  flag_phase_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ($rose(s.flag_a) || $rose(s.flag_b)) && !$past(wr_ctrl)
    |-> $past(s.phase) == dtc_pkg::DTC_PH3)
    else $error("overflow flag rose outside phase three");

  // Fast bits clear after reset release
  fast_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> !s.fast_a && !s.fast_b)
    else $error("fast time-base bits not clear after reset");

  // Sixteen-bit wrap sets timer A flag and zeroes count
  wrap_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    en_a && mode_a == dtc_pkg::DTC_M16 && {s.a_hi, s.a_lo} == 16'hFFFF
    && !bus_req.wr |=> s.flag_a && {s.a_hi, s.a_lo} == 16'h0000)
    else $error("sixteen-bit wrap did not set flag");

  // Mode 2 reload copies the high byte; timer B carries the reload traffic
  reload_copy_a: assert property (@(posedge mclk) disable iff (!rst_n)
    en_b && mode_b == dtc_pkg::DTC_MRLD && s.b_lo == dtc_pkg::BYTE_MAX
    && !bus_req.wr |=> s.b_lo == $past(s.b_hi) && $stable(s.b_hi))
    else $error("reload did not copy high byte");

  // Timer B frozen in its own mode 3
  b_frozen_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mode_b == dtc_pkg::DTC_MSPLIT && !bus_req.wr |=> $stable(s.b_lo)
    && $stable(s.b_hi))
    else $error("timer B counted in mode 3");

  // Stopped timer A holds its count
  run_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !s.run_a && !split && !bus_req.wr |=> $stable(s.a_lo) && $stable(s.a_hi))
    else $error("timer A counted without run bit");

  // Pin edge counts at the next phase three
  edge_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s.phase == dtc_pkg::DTC_PH4 && s.samp_a && !timer_a_count_pin
    && s.mode_reg[dtc_pkg::CSEL_A_BIT] |=> s.pend_a [*4])
    else $error("detected edge not held until phase three");

  // Acknowledge clears timer A flag when no set
  ack_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    irq_ack_a && !set_a && !wr_ctrl |=> !s.flag_a)
    else $error("acknowledge did not clear timer A flag");

  // Baud tick marks timer B overflow
  baud_src_a: assert property (@(posedge mclk) disable iff (!rst_n)
    baud_tick |-> $past(en_b) && $past(s.phase) == dtc_pkg::DTC_PH3)
    else $error("baud tick without timer B overflow");

  // Mode 0 step never touches the three ignored low-byte bits
  pre_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
    en_a && mode_a == dtc_pkg::DTC_M13 && !bus_req.wr
    |=> $stable(s.a_lo[7:5]))
    else $error("mode 0 step changed ignored low bits");

  // Thirteen-bit wrap from 1FFFh clears count and sets flag
  m13_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    en_a && mode_a == dtc_pkg::DTC_M13 && s.a_hi == dtc_pkg::BYTE_MAX
    && s.a_lo[4:0] == dtc_pkg::PRE_MAX && !bus_req.wr
    |=> s.flag_a && s.a_hi == 8'h00 && s.a_lo[4:0] == 5'h00)
    else $error("thirteen-bit wrap did not set flag");

  // Closed gate with gate select holds timer A
  gate_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !split && s.mode_reg[dtc_pkg::GSEL_A_BIT] && !timer_a_gate_pin
    && !bus_req.wr |=> $stable(s.a_lo) && $stable(s.a_hi))
    else $error("timer A counted with gate closed");

  // Split low byte wraps alone and raises timer A flag
  split_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    en_a && split && s.a_lo == dtc_pkg::BYTE_MAX && !bus_req.wr
    |=> s.flag_a && s.a_lo == 8'h00)
    else $error("split low byte wrap did not set flag");

  // Split high byte wrap raises timer B flag
  split_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    en_ah && s.a_hi == dtc_pkg::BYTE_MAX && !bus_req.wr
    |=> s.flag_b && s.a_hi == 8'h00)
    else $error("split high byte wrap did not set flag");

endmodule

/* File: logic/dtc_pkg.sv */
// Package for the dual timer/counter block: register offsets, field positions,
// reset values, machine-cycle constants, the bus request carrier and state types.
// Assumes a single 50 MHz clock domain and a plain synchronous register port.
package dtc_pkg;

  // Register offsets on the plain register port
  localparam logic [2:0] MODE_OFS = 3'h0; // timer_mode_register
  localparam logic [2:0] CTRL_OFS = 3'h1; // timer_control_register
  localparam logic [2:0] CLKC_OFS = 3'h2; // clock_control_register
  localparam logic [2:0] ALO_OFS = 3'h3; // timer_a_low_byte
  localparam logic [2:0] AHI_OFS = 3'h4; // timer_a_high_byte
  localparam logic [2:0] BLO_OFS = 3'h5; // timer_b_low_byte
  localparam logic [2:0] BHI_OFS = 3'h6; // timer_b_high_byte

  // Field positions inside timer_mode_register
  localparam int MODE_A_LSB = 0; // two-bit mode field, timer A
  localparam int CSEL_A_BIT = 2; // counter select, timer A
  localparam int GSEL_A_BIT = 3; // gate select, timer A
  localparam int MODE_B_LSB = 4; // two-bit mode field, timer B
  localparam int CSEL_B_BIT = 6; // counter select, timer B
  localparam int GSEL_B_BIT = 7; // gate select, timer B

  // Field positions inside timer_control_register
  localparam int RUN_A_BIT = 4;
  localparam int FLAG_A_BIT = 5;
  localparam int RUN_B_BIT = 6;
  localparam int FLAG_B_BIT = 7;

  // Field positions inside clock_control_register
  localparam int FAST_A_BIT = 3;
  localparam int FAST_B_BIT = 4;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Machine cycle and time base
  localparam int CLKS_PER_MC = 4; // system clocks per machine cycle
  localparam logic [1:0] SLOW_MC = 2'h3; // machine cycles per slow tick
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [4:0] PRE_MAX = 5'h1F; // top of the five-bit prescaler

  // Operating modes
  typedef enum logic [1:0] {
    DTC_M13 = 2'b00,
    DTC_M16 = 2'b01,
    DTC_MRLD = 2'b10,
    DTC_MSPLIT = 2'b11
  } dtc_mode_t;

  // Phases of a machine cycle, phase one first
  typedef enum logic [1:0] {
    DTC_PH1 = 2'b00,
    DTC_PH2 = 2'b01,
    DTC_PH3 = 2'b10,
    DTC_PH4 = 2'b11
  } dtc_phase_t;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dtc_bus_req_t;

  // Result of one count step
  typedef struct packed {
    logic ovf;
    logic [7:0] lo;
    logic [7:0] hi;
  } dtc_step_t;

  // Whole state of the timer block
  typedef struct packed {
    logic [7:0] mode_reg;
    logic run_a;
    logic run_b;
    logic flag_a;
    logic flag_b;
    logic fast_a;
    logic fast_b;
    logic [7:0] a_lo;
    logic [7:0] a_hi;
    logic [7:0] b_lo;
    logic [7:0] b_hi;
    dtc_phase_t phase;
    logic [1:0] div3;
    logic samp_a;
    logic samp_b;
    logic pend_a;
    logic pend_b;
    logic [7:0] rdata;
    logic baud;
  } dtc_state_t;

endpackage

/* File: tb/dtc_pins_model.sv */
// Model of the outside world at the count and gate pins of the timer block.
// Assumes the bench calls its tasks from one process and that mclk runs freely.
`timescale 1ns/1ns
module dtc_pins_model (
  input wire logic mclk,
  output logic timer_a_count_pin,
  output logic timer_b_count_pin,
  output logic timer_a_gate_pin,
  output logic timer_b_gate_pin
);
  // Count pins idle high, gates closed until the bench opens them
  initial begin
    timer_a_count_pin = 1'b1;
    timer_b_count_pin = 1'b1;
    timer_a_gate_pin = 1'b0;
    timer_b_gate_pin = 1'b0;
  end

  // Falling edges on the timer A count pin, one every 24 clocks
  task automatic send_pulses(input int n);
    repeat (n) begin
      @(posedge mclk);
      timer_a_count_pin <= 1'b0;
      // Each level spans three machine cycles, so no edge is lost
      repeat (12) @(posedge mclk);
      timer_a_count_pin <= 1'b1;
      repeat (11) @(posedge mclk);
    end
  endtask

  // Gate levels change just after an edge
  task automatic set_gates(input logic ga, input logic gb);
    @(posedge mclk);
    timer_a_gate_pin <= ga;
    timer_b_gate_pin <= gb;
  endtask
endmodule

/* File: tb/dual_timer_counter_tb_top.sv */
// Self-checking bench for the dual timer/counter: register accesses, modes and pins.
// Assumes the pin model beside it and the register offsets of the package.
`timescale 1ns/1ns
module dual_timer_counter_tb_top;
  logic mclk;
  logic rst_n;
  dtc_pkg::dtc_bus_req_t bus_req;
  logic [7:0] bus_rdata;
  logic ta_pin, tb_pin, ga_pin, gb_pin; // Pins from the model
  logic irq_ack_a, irq_ack_b;
  logic flag_a, flag_b, baud_tick;
  int bad_count, tests_run, cyc, n;
  logic [7:0] v;
  logic hit;

  dtc_timer u_dtc_timer (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .timer_a_count_pin(ta_pin), .timer_b_count_pin(tb_pin),
    .timer_a_gate_pin(ga_pin), .timer_b_gate_pin(gb_pin), .irq_ack_a(irq_ack_a),
    .irq_ack_b(irq_ack_b), .timer_a_overflow_flag(flag_a),
    .timer_b_overflow_flag(flag_b), .baud_tick(baud_tick));

  dtc_pins_model u_dtc_pins_model (.mclk(mclk), .timer_a_count_pin(ta_pin),
    .timer_b_count_pin(tb_pin), .timer_a_gate_pin(ga_pin), .timer_b_gate_pin(gb_pin));

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  // Single comparison point
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle only
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    @(negedge mclk);
    d = bus_rdata;
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check({8'h00, d}, {8'h00, exp});
  endtask

  // Bounded wait for flag A (0), flag B (1) or the baud pulse (2)
  task automatic wait_on(input int sel, input int lim, output logic h);
    h = 1'b0;
    for (int i = 0; i < lim && h !== 1'b1; i++) begin
      @(negedge mclk);
      h = (sel == 0) ? flag_a : (sel == 1) ? flag_b : baud_tick;
    end
  endtask

  // Clocks between two consecutive baud pulses
  task automatic gap(output int g);
    logic h;
    wait_on(2, 100, h);
    g = 0;
    do begin
      @(negedge mclk);
      g++;
    end while (baud_tick !== 1'b1 && g < 100);
  endtask

  // One-cycle interrupt acknowledge, flag read back after it lands
  task automatic ack(input logic b);
    @(posedge mclk);
    if (b) irq_ack_b <= 1'b1;
    else irq_ack_a <= 1'b1;
    @(posedge mclk);
    irq_ack_a <= 1'b0;
    irq_ack_b <= 1'b0;
    @(negedge mclk);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    bus_req = '0;
    irq_ack_a = 1'b0;
    irq_ack_b = 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    // Every register clears, the unmapped offset reads zero
    for (int a = 0; a < 8; a++) rchk(a[2:0], 8'h00);
    wr(dtc_pkg::MODE_OFS, 8'hA5);
    rchk(dtc_pkg::MODE_OFS, 8'hA5);
    @(negedge mclk);
    check({8'h00, bus_rdata}, 16'h0000);
    // Timer B reload from FF: one overflow per tick
    wr(dtc_pkg::BHI_OFS, 8'hFF);
    wr(dtc_pkg::BLO_OFS, 8'hFF);
    wr(dtc_pkg::MODE_OFS, 8'h20);
    wr(dtc_pkg::CTRL_OFS, 8'h40);
    gap(n);
    check(n[15:0], 16'h000C);
    check({15'h0000, flag_b}, 16'h0001);
    rchk(dtc_pkg::BHI_OFS, 8'hFF);
    wr(dtc_pkg::CLKC_OFS, 8'h10);
    gap(n);
    check(n[15:0], 16'h0004);
    wr(dtc_pkg::CTRL_OFS, 8'h00);
    wr(dtc_pkg::CLKC_OFS, 8'h00);
    // Thirteen-bit count: two slow ticks from 1FFEh to the wrap
    wr(dtc_pkg::AHI_OFS, 8'hFF);
    wr(dtc_pkg::ALO_OFS, 8'hFE);
    wr(dtc_pkg::MODE_OFS, 8'h00);
    wr(dtc_pkg::CTRL_OFS, 8'h10);
    wait_on(0, 40, hit);
    check({15'h0000, hit}, 16'h0001);
    rchk(dtc_pkg::AHI_OFS, 8'h00);
    rd(dtc_pkg::ALO_OFS, v);
    check({8'h00, v}, 16'h00E0);
    ack(1'b0);
    check({15'h0000, flag_a}, 16'h0000);
    wr(dtc_pkg::CTRL_OFS, 8'h00);
    // Sixteen-bit wrap on the fast time base
    wr(dtc_pkg::CLKC_OFS, 8'h08);
    wr(dtc_pkg::MODE_OFS, 8'h01);
    wr(dtc_pkg::AHI_OFS, 8'hFF);
    wr(dtc_pkg::ALO_OFS, 8'hFF);
    wr(dtc_pkg::CTRL_OFS, 8'h10);
    wait_on(0, 12, hit);
    check({15'h0000, hit}, 16'h0001);
    rchk(dtc_pkg::ALO_OFS, 8'h00);
    rchk(dtc_pkg::CTRL_OFS, 8'h30);
    wr(dtc_pkg::CTRL_OFS, 8'h00);
    // Gate select with the gate pin closed, then open
    wr(dtc_pkg::MODE_OFS, 8'h09);
    wr(dtc_pkg::AHI_OFS, 8'h00);
    wr(dtc_pkg::ALO_OFS, 8'h00);
    wr(dtc_pkg::CTRL_OFS, 8'h10);
    repeat (40) @(posedge mclk);
    rchk(dtc_pkg::ALO_OFS, 8'h00);
    u_dtc_pins_model.set_gates(1'b1, 1'b0);
    repeat (40) @(posedge mclk);
    rd(dtc_pkg::ALO_OFS, v);
    check({15'h0000, v >= 8'h09 && v <= 8'h0C}, 16'h0001);
    wr(dtc_pkg::CTRL_OFS, 8'h00);
    // External edges counted one for one
    wr(dtc_pkg::MODE_OFS, 8'h05);
    wr(dtc_pkg::ALO_OFS, 8'h00);
    wr(dtc_pkg::CTRL_OFS, 8'h10);
    u_dtc_pins_model.send_pulses(5);
    repeat (24) @(posedge mclk);
    rchk(dtc_pkg::ALO_OFS, 8'h05);
    wr(dtc_pkg::CTRL_OFS, 8'h00);
    // Split mode: B reloads without its run bit, raises no flag
    wr(dtc_pkg::BLO_OFS, 8'hFF);
    wr(dtc_pkg::AHI_OFS, 8'hFF);
    wr(dtc_pkg::ALO_OFS, 8'hFF);
    wr(dtc_pkg::CLKC_OFS, 8'h18);
    wr(dtc_pkg::MODE_OFS, 8'h23);
    wr(dtc_pkg::CTRL_OFS, 8'h10);
    gap(n);
    check(n[15:0], 16'h0004);
    check({15'h0000, flag_b}, 16'h0000);
    rchk(dtc_pkg::AHI_OFS, 8'hFF);
    check({15'h0000, flag_a}, 16'h0001);
    wr(dtc_pkg::CTRL_OFS, 8'h50);
    wait_on(1, 20, hit);
    check({15'h0000, hit}, 16'h0001);
    ack(1'b1);
    check({15'h0000, flag_b}, 16'h0000);
    // Timer B in its own split mode stands still
    wr(dtc_pkg::MODE_OFS, 8'h33);
    rd(dtc_pkg::BLO_OFS, v);
    wait_on(2, 30, hit);
    check({15'h0000, hit}, 16'h0000);
    rchk(dtc_pkg::BLO_OFS, v);
    final_report();
  end
endmodule
